// *** common/ebt_pkg.sv ***
// Package with register map, field layout and shared types for the 8-bit timer
package ebt_pkg;

    // ------------------------------------------------------------------
    // Register offsets on the special function register port
    // ------------------------------------------------------------------
    localparam logic [7:0] EBT_ADDR_COUNTER_VALUE = 8'hca;
    localparam logic [7:0] EBT_ADDR_TIMER_CONTROL = 8'hcb;
    localparam logic [7:0] EBT_ADDR_CHAN0_CONTROL = 8'hcc;
    localparam logic [7:0] EBT_ADDR_CHAN0_COMPARE = 8'hcd;
    localparam logic [7:0] EBT_ADDR_CHAN1_CONTROL = 8'hce;
    localparam logic [7:0] EBT_ADDR_CHAN1_COMPARE = 8'hcf;
    localparam logic [7:0] EBT_ADDR_TIMER_FLAGS   = 8'hd8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int EBT_CTL_DIV_LSB   = 5;
    localparam int EBT_CTL_START_BIT = 4;
    localparam int EBT_CTL_TERMINAL_COUNT_IRQ_MASK_BIT = 3;
    localparam int EBT_CTL_CLR_BIT   = 2;
    localparam int EBT_CTL_MODE_LSB  = 0;
    localparam int EBT_CCTL_IM_BIT   = 6;
    localparam int EBT_CCTL_CMP_LSB  = 3;
    localparam int EBT_CCTL_EN_BIT   = 2;
    localparam int EBT_FLG_TC_BIT    = 0;
    localparam int EBT_FLG_CH0_BIT   = 1;
    localparam int EBT_FLG_CH1_BIT   = 2;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] EBT_CTL_RESET   = 8'h08;
    localparam logic [7:0] EBT_CCTL_RESET  = 8'h40;
    localparam logic [7:0] EBT_CCTL_WMASK  = 8'h7f;
    localparam logic [7:0] EBT_CTL_WMASK   = 8'hfb;
    localparam logic [7:0] EBT_ZERO        = 8'h00;
    localparam logic [7:0] EBT_TOP         = 8'hff;
    localparam logic [6:0] EBT_PRE_ONE     = 7'h01;
    localparam logic [7:0] EBT_CNT_ONE     = 8'h01;

    // ------------------------------------------------------------------
    // Counting modes and compare output actions
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EBT_MODE_FREE   = 2'h0,
        EBT_MODE_DOWN   = 2'h1,
        EBT_MODE_MODULO = 2'h2,
        EBT_MODE_UPDOWN = 2'h3
    } ebt_mode_t;

    localparam logic [2:0] EBT_ACT_SET      = 3'h0;
    localparam logic [2:0] EBT_ACT_CLEAR    = 3'h1;
    localparam logic [2:0] EBT_ACT_TOGGLE   = 3'h2;
    localparam logic [2:0] EBT_ACT_SET_UP   = 3'h3;
    localparam logic [2:0] EBT_ACT_CLR_UP   = 3'h4;
    localparam logic [2:0] EBT_ACT_SET_ALT  = 3'h5;
    localparam logic [2:0] EBT_ACT_CLR_ALT  = 3'h6;

    // ------------------------------------------------------------------
    // Register port request and complete block state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } ebt_sfr_req_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic       dir_down;
        logic [6:0] pre;
        logic [7:0] ctl;
        logic [7:0] cctl0;
        logic [7:0] cctl1;
        logic [7:0] cc0_wr;
        logic [7:0] cc0_act;
        logic [7:0] cc1;
        logic [2:0] flags;
        logic [1:0] pins;
        logic       irq;
        logic [1:0] dma;
        logic [7:0] rdata;
    } ebt_state_t;

endpackage : ebt_pkg

// *** rtl/ebt_timer.sv ***
// 8-bit timer with prescaler, four counting modes and two compare channels
`timescale 1ns/100ps

module ebt_timer
    import ebt_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_nrst,
    input  wire logic       i_tick,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic       i_sfr_rd,
    input  wire logic [7:0] i_sfr_wdata,
    output logic      [7:0] o_sfr_rdata,
    output logic      [1:0] o_cmp_pin,
    output logic            o_irq,
    output logic            o_dma_trig_chan0,
    output logic            o_dma_trig_chan1
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Low prescaler bits that must all be one for an active edge
    function automatic logic [6:0] ebt_div_mask(input logic [2:0] div);
        ebt_div_mask = 7'((8'h01 << div) - 8'h01);
    endfunction : ebt_div_mask

    // Next level of a compare pin for one active edge
    function automatic logic ebt_pin_next(input logic [2:0] act,
                                          input logic       cur,
                                          input logic       hit,
                                          input logic       up,
                                          input logic       zero,
                                          input logic       alt_clr,
                                          input logic       alt_set);
        logic v;
        v = cur;
        unique case (act)
            EBT_ACT_SET:     if (hit) v = 1'b1;
            EBT_ACT_CLEAR:   if (hit) v = 1'b0;
            EBT_ACT_TOGGLE:  if (hit) v = ~cur;
            EBT_ACT_SET_UP: begin
                if (zero) v = 1'b0;
                if (hit) v = up;
            end
            EBT_ACT_CLR_UP: begin
                if (zero) v = 1'b1;
                if (hit) v = ~up;
            end
            EBT_ACT_SET_ALT: begin
                if (alt_clr) v = 1'b0;
                if (hit) v = 1'b1;
            end
            EBT_ACT_CLR_ALT: begin
                if (alt_set) v = 1'b1;
                if (hit) v = 1'b0;
            end
            default: v = cur;
        endcase
        ebt_pin_next = v;
    endfunction : ebt_pin_next

    // ------------------------------------------------------------------
    // State and decoded request
    // ------------------------------------------------------------------
    ebt_state_t   s_r;
    ebt_state_t   s_nxt;
    ebt_sfr_req_t req;
    ebt_mode_t    mode;
    logic         edge_act;
    logic         running;
    logic         wr_ctl;
    logic         hit0;
    logic         hit1;
    logic         tc_ev;
    logic [2:0]   set_ev;
    logic         up_cnt;

    assign req  = '{addr: i_sfr_addr, wr: i_sfr_wr, rd: i_sfr_rd, wdata: i_sfr_wdata};
    assign mode = ebt_mode_t'(s_r.ctl[EBT_CTL_MODE_LSB +: 2]);

    // Active edge of the prescaled tick
    assign edge_act = i_tick && ((s_r.pre & ebt_div_mask(s_r.ctl[EBT_CTL_DIV_LSB +: 3]))
                      == ebt_div_mask(s_r.ctl[EBT_CTL_DIV_LSB +: 3]));
    assign running  = edge_act && s_r.ctl[EBT_CTL_START_BIT];
    assign wr_ctl   = req.wr && (req.addr == EBT_ADDR_TIMER_CONTROL);
    assign up_cnt   = (mode != EBT_MODE_DOWN) && !s_r.dir_down;

    // Compare matches of the running counter, gated by channel enable
    assign hit0 = running && s_r.cctl0[EBT_CCTL_EN_BIT] && (s_r.cnt == s_r.cc0_act);
    assign hit1 = running && s_r.cctl1[EBT_CCTL_EN_BIT] && (s_r.cnt == s_r.cc1);

    // Terminal-count event per mode
    always_comb begin
        tc_ev = 1'b0;
        if (running) begin
            unique case (mode)
                EBT_MODE_FREE:   tc_ev = (s_r.cnt == EBT_TOP);
                EBT_MODE_DOWN:   tc_ev = (s_r.cnt == EBT_CNT_ONE);
                EBT_MODE_MODULO: tc_ev = (s_r.cnt >= s_r.cc0_act);
                EBT_MODE_UPDOWN: tc_ev = s_r.dir_down && (s_r.cnt == EBT_CNT_ONE);
            endcase
        end
    end
    assign set_ev = {hit1, hit0, tc_ev};

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt     = s_r;
        s_nxt.dma = 2'h0;
        if (i_tick) begin
            s_nxt.pre = s_r.pre + EBT_PRE_ONE;
        end

        // Counter stepping
        if (running) begin
            unique case (mode)
                EBT_MODE_FREE: s_nxt.cnt = s_r.cnt + EBT_CNT_ONE;
                EBT_MODE_DOWN: begin
                    if (s_r.cnt != EBT_ZERO) s_nxt.cnt = s_r.cnt - EBT_CNT_ONE;
                end
                EBT_MODE_MODULO: begin
                    s_nxt.cnt = tc_ev ? EBT_ZERO : s_r.cnt + EBT_CNT_ONE;
                end
                EBT_MODE_UPDOWN: begin
                    if (!s_r.dir_down && (s_r.cnt >= s_r.cc0_act)) begin
                        s_nxt.dir_down = (s_r.cnt != EBT_ZERO);
                        s_nxt.cnt      = (s_r.cnt != EBT_ZERO) ? s_r.cnt - EBT_CNT_ONE
                                                               : EBT_ZERO;
                    end else if (s_r.dir_down && (s_r.cnt == EBT_ZERO)) begin
                        s_nxt.dir_down = 1'b0;
                        s_nxt.cnt      = EBT_CNT_ONE;
                    end else if (s_r.dir_down) begin
                        s_nxt.cnt = s_r.cnt - EBT_CNT_ONE;
                    end else begin
                        s_nxt.cnt = s_r.cnt + EBT_CNT_ONE;
                    end
                end
            endcase
        end

        // Channel 0 compare takes effect at count zero, or on a start in down mode
        if (s_r.cnt == EBT_ZERO) begin
            s_nxt.cc0_act = s_r.cc0_wr;
        end

        // Compare pins, registered so every edge is clean
        if (running) begin
            s_nxt.pins[0] = ebt_pin_next(s_r.cctl0[EBT_CCTL_CMP_LSB +: 3], s_r.pins[0],
                                         hit0, up_cnt,
                                         s_r.cctl0[EBT_CCTL_EN_BIT] && s_r.cnt == EBT_ZERO,
                                         s_r.cctl0[EBT_CCTL_EN_BIT] && s_r.cnt == EBT_TOP,
                                         s_r.cctl0[EBT_CCTL_EN_BIT] && s_r.cnt == EBT_ZERO);
            s_nxt.pins[1] = ebt_pin_next(s_r.cctl1[EBT_CCTL_CMP_LSB +: 3], s_r.pins[1],
                                         hit1, up_cnt,
                                         s_r.cctl1[EBT_CCTL_EN_BIT] && s_r.cnt == EBT_ZERO,
                                         s_r.cctl1[EBT_CCTL_EN_BIT] && s_r.cnt == s_r.cc0_act,
                                         s_r.cctl1[EBT_CCTL_EN_BIT] && s_r.cnt == s_r.cc0_act);
        end
        s_nxt.dma = {hit1, hit0};

        // Register writes
        if (req.wr) begin
            unique case (req.addr)
                EBT_ADDR_TIMER_CONTROL: begin
                    s_nxt.ctl = req.wdata & EBT_CTL_WMASK;
                    if (req.wdata[EBT_CTL_START_BIT] && !s_r.ctl[EBT_CTL_START_BIT] &&
                        req.wdata[EBT_CTL_MODE_LSB +: 2] == EBT_MODE_DOWN) begin
                        s_nxt.cnt     = s_r.cc0_wr;
                        s_nxt.cc0_act = s_r.cc0_wr;
                    end
                    if (req.wdata[EBT_CTL_CLR_BIT]) begin
                        s_nxt.cnt      = EBT_ZERO;
                        s_nxt.dir_down = 1'b0;
                    end
                end
                EBT_ADDR_CHAN0_CONTROL: s_nxt.cctl0 = req.wdata & EBT_CCTL_WMASK;
                EBT_ADDR_CHAN0_COMPARE: s_nxt.cc0_wr = req.wdata;
                EBT_ADDR_CHAN1_CONTROL: s_nxt.cctl1 = req.wdata & EBT_CCTL_WMASK;
                EBT_ADDR_CHAN1_COMPARE: s_nxt.cc1 = req.wdata;
                EBT_ADDR_TIMER_FLAGS:   s_nxt.flags = s_r.flags & req.wdata[2:0];
                default:                s_nxt.ctl = s_nxt.ctl;
            endcase
        end

        // Hardware set wins over a software clear in the same cycle
        s_nxt.flags = s_nxt.flags | set_ev;

        // One request line, level while any enabled flag is pending
        s_nxt.irq = |(s_r.flags & {s_r.cctl1[EBT_CCTL_IM_BIT], s_r.cctl0[EBT_CCTL_IM_BIT],
                                   s_r.ctl[EBT_CTL_TERMINAL_COUNT_IRQ_MASK_BIT]});

        // Registered read data
        s_nxt.rdata = EBT_ZERO;
        if (req.rd) begin
            unique case (req.addr)
                EBT_ADDR_COUNTER_VALUE: s_nxt.rdata = s_r.cnt;
                EBT_ADDR_TIMER_CONTROL: s_nxt.rdata = s_r.ctl;
                EBT_ADDR_CHAN0_CONTROL: s_nxt.rdata = s_r.cctl0;
                EBT_ADDR_CHAN0_COMPARE: s_nxt.rdata = s_r.cc0_wr;
                EBT_ADDR_CHAN1_CONTROL: s_nxt.rdata = s_r.cctl1;
                EBT_ADDR_CHAN1_COMPARE: s_nxt.rdata = s_r.cc1;
                EBT_ADDR_TIMER_FLAGS:   s_nxt.rdata = {5'h00, s_r.flags};
                default:                s_nxt.rdata = EBT_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_r       <= '0;
            s_r.ctl   <= EBT_CTL_RESET;
            s_r.cctl0 <= EBT_CCTL_RESET;
            s_r.cctl1 <= EBT_CCTL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign o_sfr_rdata      = s_r.rdata;
    assign o_cmp_pin        = s_r.pins;
    assign o_irq            = s_r.irq;
    assign o_dma_trig_chan0 = s_r.dma[0];
    assign o_dma_trig_chan1 = s_r.dma[1];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    clear_count_a: assert property (wr_ctl && req.wdata[EBT_CTL_CLR_BIT]
        |=> s_r.cnt == EBT_ZERO && !s_r.dir_down && !s_r.ctl[EBT_CTL_CLR_BIT])
        else $error("Clear did not zero the counter");

    halt_hold_a: assert property (!s_r.ctl[EBT_CTL_START_BIT] && !wr_ctl
        |=> $stable(s_r.cnt))
        else $error("Halted counter moved");

    edge_only_a: assert property (!edge_act && !wr_ctl
        |=> s_r.cnt == $past(s_r.cnt))
        else $error("Counter stepped without an active edge");

    free_wrap_a: assert property (running && mode == EBT_MODE_FREE &&
        s_r.cnt == EBT_TOP && !req.wr
        |=> s_r.cnt == EBT_ZERO && s_r.flags[EBT_FLG_TC_BIT])
        else $error("Free mode did not wrap with flag");

    down_hold_a: assert property (running && mode == EBT_MODE_DOWN &&
        s_r.cnt == EBT_ZERO && !wr_ctl |=> s_r.cnt == EBT_ZERO)
        else $error("Down mode left zero");

    modulo_wrap_a: assert property (running && mode == EBT_MODE_MODULO &&
        s_r.cnt == s_r.cc0_act && !wr_ctl
        |=> s_r.cnt == EBT_ZERO && s_r.flags[EBT_FLG_TC_BIT])
        else $error("Modulo mode did not return to zero");

    irq_level_a: assert property (s_r.flags[EBT_FLG_CH1_BIT] &&
        s_r.cctl1[EBT_CCTL_IM_BIT] |=> o_irq)
        else $error("Channel 1 request missing");

    dma_pulse_a: assert property (hit0 |=> o_dma_trig_chan0 ##1
        (!o_dma_trig_chan0 || $past(hit0)))
        else $error("Channel 0 trigger not a pulse");

    cc1_now_a: assert property (req.wr && req.addr == EBT_ADDR_CHAN1_COMPARE
        |=> s_r.cc1 == $past(req.wdata))
        else $error("Channel 1 compare not immediate");

    flag_sticky_a: assert property (s_r.flags[EBT_FLG_CH0_BIT] &&
        !(req.wr && req.addr == EBT_ADDR_TIMER_FLAGS) |=> s_r.flags[EBT_FLG_CH0_BIT])
        else $error("Channel 0 flag dropped by itself");

    cc0_defer_a: assert property (s_r.cnt != EBT_ZERO && !wr_ctl
        |=> $stable(s_r.cc0_act))
        else $error("Channel 0 compare applied away from zero");

    cc0_apply_a: assert property (s_r.cnt == EBT_ZERO
        |=> s_r.cc0_act == $past(s_r.cc0_wr))
        else $error("Channel 0 compare not applied at zero");

    chan0_irq_a: assert property (s_r.flags[EBT_FLG_CH0_BIT] &&
        s_r.cctl0[EBT_CCTL_IM_BIT] |=> o_irq)
        else $error("Channel 0 request missing");

    irq_masked_a: assert property ((s_r.flags & {s_r.cctl1[EBT_CCTL_IM_BIT],
        s_r.cctl0[EBT_CCTL_IM_BIT], s_r.ctl[EBT_CTL_TERMINAL_COUNT_IRQ_MASK_BIT]}) == 3'h0 |=> !o_irq)
        else $error("Request raised with nothing enabled pending");

    hit_flag_a: assert property (hit1 |=> s_r.flags[EBT_FLG_CH1_BIT] &&
        o_dma_trig_chan1)
        else $error("Channel 1 match lost its flag or trigger");

    pin_frozen_a: assert property (!running |=> $stable(o_cmp_pin))
        else $error("Compare pin moved while not running");

    clr_reads_a: assert property (req.rd && req.addr == EBT_ADDR_TIMER_CONTROL
        |=> !o_sfr_rdata[EBT_CTL_CLR_BIT])
        else $error("Clear bit read back as one");

    updown_top_a: assert property (running && mode == EBT_MODE_UPDOWN &&
        !s_r.dir_down && s_r.cnt == s_r.cc0_act && s_r.cnt != EBT_ZERO && !wr_ctl
        |=> s_r.dir_down)
        else $error("Up/down did not turn at channel 0 compare");

    free_wrap_c:  cover property (running && mode == EBT_MODE_FREE && s_r.cnt == EBT_TOP);
    updown_rev_c: cover property (running && mode == EBT_MODE_UPDOWN && s_nxt.dir_down
                                  && !s_r.dir_down);
    toggle_c:     cover property (hit0 && s_r.cctl0[EBT_CCTL_CMP_LSB +: 3] == EBT_ACT_TOGGLE);
    irq_c:        cover property ($rose(o_irq));
    cc0_defer_c:  cover property (req.wr && req.addr == EBT_ADDR_CHAN0_COMPARE
                                  && s_r.cnt != EBT_ZERO);

endmodule : ebt_timer

// *** verification/ebt_cpu_model.sv ***
// CPU side model of the special function register port
`timescale 1ns/100ps
module ebt_cpu_model (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_rdata,
    output logic      [7:0] o_addr,
    output logic            o_wr,
    output logic            o_rd,
    output logic      [7:0] o_wdata
);
    // Idle bus with both strobes low
    initial begin
        o_addr  = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 8'h00;
    end
    // One write, held across exactly one taking edge, then lines inverted
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_addr  = a;
        o_wdata = d;
        o_wr    = 1'b1;
        @(negedge i_mclk);
        o_wr    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d;
    endtask : wr_reg
    // One read; data stands for the cycle after the taking edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_mclk);
        o_addr = a;
        o_rd   = 1'b1;
        @(negedge i_mclk);
        o_rd   = 1'b0;
        o_addr = ~a;
        d      = i_rdata;
    endtask : rd_reg
endmodule : ebt_cpu_model

// *** verification/ebt_timer_tb.sv ***
// Self-checking bench for the 8-bit timer with two compare channels
`timescale 1ns/100ps
module ebt_timer_tb;
    import ebt_pkg::*;
    logic [7:0] addr, wdata, rdata, v, cmpv;
    logic       mclk, nrst, tick, wr, rd, irq, dma0, dma1, pl;
    logic [1:0] pin;
    logic [6:0] tk, t0;
    int         error_cnt, n_compared, cyc, dma0_cnt, dma1_cnt, dv, n;
    localparam logic [7:0] RADR [8] = '{8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hce, 8'hcf, 8'hd8, 8'hd0};
    localparam logic [7:0] RVAL [8] = '{8'h00, 8'h08, 8'h40, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
    // Mode, channel 0 compare, tick count, expected count
    localparam logic [7:0] MTAB [4][4] = '{'{8'h00, 8'h09, 8'h03, 8'h03},
        '{8'h01, 8'h05, 8'h07, 8'h00}, '{8'h02, 8'h03, 8'h04, 8'h00},
        '{8'h03, 8'h03, 8'h04, 8'h02}};

    ebt_timer dut (.i_mclk(mclk), .i_nrst(nrst), .i_tick(tick), .i_sfr_addr(addr),
        .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
        .o_cmp_pin(pin), .o_irq(irq), .o_dma_trig_chan0(dma0), .o_dma_trig_chan1(dma1));
    ebt_cpu_model cpu (.i_mclk(mclk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
        .o_rd(rd), .o_wdata(wdata));

    // Clock of 4 ns period
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Cycle ceiling and trigger pulse counts, sampled away from the launching edge
    always @(negedge mclk) begin
        cyc++;
        if (dma0 === 1'b1) dma0_cnt++;
        if (dma1 === 1'b1) dma1_cnt++;
        if (cyc == 30000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // Active edges among n ticks starting at prescaler phase p
    function automatic int steps(input logic [6:0] p, input int cnt, input int d);
        logic [6:0] m;
        m = (7'h01 << d) - 7'h01;
        steps = 0;
        for (int i = 0; i < cnt; i++) if (((p + 7'(i)) & m) == m) steps++;
    endfunction : steps
    // Channel 0 pin level after n free-running steps from zero, per action code
    function automatic logic pin_exp(input logic [2:0] a, input logic p,
                                     input logic [7:0] cv, input int cnt);
        logic [7:0] c;
        pin_exp = p;
        for (int i = 0; i < cnt; i++) begin
            c = 8'(i);
            if (c == 8'h00 && (a == 3'h3 || a == 3'h4 || a == 3'h6)) pin_exp = (a != 3'h3);
            if (c == 8'hff && a == 3'h5) pin_exp = 1'b0;
            if (c == cv) pin_exp = (a == 3'h2) ? ~pin_exp : (a == 3'h0 || a == 3'h3 || a == 3'h5);
        end
    endfunction : pin_exp
    // Compare matches among n free-running steps from zero
    function automatic int hits(input logic [7:0] cv, input int cnt);
        hits = 0;
        for (int i = 0; i < cnt; i++) if (8'(i) == cv) hits++;
    endfunction : hits
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        cpu.rd_reg(a, v);
        chk(nm, v, e);
    endtask : rchk
    // Back-to-back tick pulses, one per cycle
    task automatic pulse(input int cnt);
        repeat (cnt) begin
            @(negedge mclk);
            tick = 1'b1;
            tk = tk + 7'h01;
        end
        @(negedge mclk);
        tick = 1'b0;
    endtask : pulse
    // Clear and stop, load channel 0 compare, start, then tick
    task automatic run(input logic [7:0] cc0, input logic [7:0] ctl, input int cnt);
        cpu.wr_reg(8'hcb, 8'h04);
        cpu.wr_reg(8'hcd, cc0);
        cpu.wr_reg(8'hcb, ctl);
        t0 = tk;
        pulse(cnt);
    endtask : run
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic irq_is(input string nm, input logic e);
        repeat (2) @(negedge mclk);
        chk(nm, irq, e);
    endtask : irq_is

    // Main sequence
    initial begin
        nrst = 1'b0;
        tick = 1'b0;
        tk = 7'h00;
        void'($urandom(32'hc625));
        repeat (16) @(negedge mclk);
        nrst = 1'b1;
        cpu.wr_reg(8'hd0, 8'h55);
        for (int i = 0; i < 8; i++) rchk("reset_value", RADR[i], RVAL[i]);
        cpu.wr_reg(8'hcc, 8'hff);
        rchk("chan_ctl", 8'hcc, 8'h7f);
        cpu.wr_reg(8'hcb, 8'h07);
        rchk("clear_bit", 8'hcb, 8'h03);
        cpu.wr_reg(8'hcc, 8'h00);
        cpu.wr_reg(8'hce, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            dv = (i == 4) ? 7 : $urandom_range(0, 3);
            n = (i == 4) ? 130 : $urandom_range(1, 60);
            run(8'h00, 8'(dv << 5) | 8'h10, n);
            rchk("prescaled_count", 8'hca, 8'(steps(t0, n, dv)));
        end
        $display("test prescaler done");
        for (int i = 0; i < 4; i++) begin
            run(MTAB[i][1], MTAB[i][0] | 8'h10, int'(MTAB[i][2]));
            rchk("mode_count", 8'hca, MTAB[i][3]);
        end
        cpu.wr_reg(8'hcb, 8'h17);
        pulse(2);
        rchk("clear_direction", 8'hca, 8'h02);
        cpu.wr_reg(8'hcb, 8'h03);
        pulse(3);
        rchk("halted_count", 8'hca, 8'h02);
        $display("test modes done");
        run(8'h00, 8'h18, 255);
        cpu.wr_reg(8'hd8, 8'h00);
        rchk("count_top", 8'hca, 8'hff);
        rchk("flags_before_wrap", 8'hd8, 8'h00);
        pulse(1);
        irq_is("irq_on_wrap", 1'b1);
        cpu.rd_reg(8'hd8, v);
        chk("terminal_flag", v[0], 1'b1);
        cpu.wr_reg(8'hcb, 8'h10);
        irq_is("irq_masked", 1'b0);
        cpu.rd_reg(8'hd8, v);
        chk("flag_kept", v[0], 1'b1);
        cpu.wr_reg(8'hcb, 8'h18);
        irq_is("irq_on_unmask", 1'b1);
        cpu.wr_reg(8'hd8, 8'h00);
        irq_is("irq_cleared", 1'b0);
        $display("test interrupt done");
        cpu.wr_reg(8'hce, 8'h14);
        cpu.wr_reg(8'hcf, 8'h03);
        dma1_cnt = 0;
        run(8'h00, 8'h10, 5);
        chk("pin_toggle", pin[1], 1'b1);
        chk("pin_disabled", pin[0], 1'b0);
        chk("dma_pulses", 8'(dma1_cnt), 8'h01);
        cpu.rd_reg(8'hd8, v);
        chk("chan1_flag", v[2], 1'b1);
        $display("test compare done");
        pl = 1'b0;
        for (int a = 0; a < 7; a++) begin
            cmpv = 8'($urandom_range(0, 60));
            n = (a == 5) ? 300 : $urandom_range(1, 300);
            cpu.wr_reg(8'hcc, 8'(a << 3) | 8'h04);
            dma0_cnt = 0;
            run(cmpv, 8'h10, n);
            rchk("free_count", 8'hca, 8'(n));
            pl = pin_exp(3'(a), pl, cmpv, n);
            chk("chan0_pin", pin[0], pl);
            chk("chan0_dma", 8'(dma0_cnt), 8'(hits(cmpv, n)));
        end
        cpu.wr_reg(8'hd8, 8'h00);
        run(8'h05, 8'h12, 3);
        cpu.wr_reg(8'hcd, 8'h02);
        pulse(3);
        rchk("cc0_deferred", 8'hca, 8'h00);
        cpu.rd_reg(8'hd8, v);
        chk("modulo_flag", v[0], 1'b1);
        pulse(3);
        rchk("cc0_applied", 8'hca, 8'h00);
        cpu.wr_reg(8'hce, 8'h5c);
        cpu.wr_reg(8'hcf, 8'h02);
        cpu.wr_reg(8'hd8, 8'h00);
        run(8'h06, 8'h13, 8);
        chk("pin_up_match", pin[1], 1'b1);
        irq_is("irq_on_compare", 1'b1);
        pulse(3);
        chk("pin_down_match", pin[1], 1'b0);
        rchk("updown_count", 8'hca, 8'h01);
        $display("test actions done");
        wrap_up();
    end
endmodule : ebt_timer_tb
